/* rtl/ctp_pkg.sv */
package ctp_pkg;

    localparam int CNT_W = 16;
    localparam int PRESC_W = 12;
    localparam int EXP_W = 4;

    // count clock select codes, divider is fc / 2**exponent
    localparam logic [2:0] CK_DIV11 = 3'h0;
    localparam logic [2:0] CK_DIV7 = 3'h1;
    localparam logic [2:0] CK_DIV5 = 3'h2;
    localparam logic [2:0] CK_DIV3 = 3'h3;
    localparam logic [2:0] CK_DIV2 = 3'h4;
    localparam logic [2:0] CK_DIV1 = 3'h5;
    localparam logic [2:0] CK_UNUSED = 3'h6;
    localparam logic [2:0] CK_EXT = 3'h7;

    localparam logic [EXP_W-1:0] EXP_11 = 4'hB;
    localparam logic [EXP_W-1:0] EXP_7 = 4'h7;
    localparam logic [EXP_W-1:0] EXP_5 = 4'h5;
    localparam logic [EXP_W-1:0] EXP_3 = 4'h3;
    localparam logic [EXP_W-1:0] EXP_2 = 4'h2;
    localparam logic [EXP_W-1:0] EXP_1 = 4'h1;
    localparam logic [EXP_W-1:0] EXP_EXTRA = 4'h1;

    // register count field
    localparam logic [1:0] RC_A = 2'h0;
    localparam logic [1:0] RC_AB = 2'h1;
    localparam logic [1:0] RC_ABC = 2'h2;

    // compare write select
    localparam logic [1:0] SEL_A = 2'h0;
    localparam logic [1:0] SEL_B = 2'h1;
    localparam logic [1:0] SEL_C = 2'h2;

    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [PRESC_W-1:0] PRESC_ZERO = 12'h000;
    localparam logic [PRESC_W-1:0] PRESC_ONE = 12'h001;

    typedef struct packed {
        logic             sync1;
        logic             sync2;
        logic             prev;
        logic             started;
        logic             running;
        logic             ff;
        logic             irq;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] cmp_a;
        logic [CNT_W-1:0] cmp_b;
        logic [CNT_W-1:0] cmp_c;
    } ctp_state_t;

    typedef struct packed {
        logic [PRESC_W-1:0] cnt;
        logic               tick;
    } ctp_presc_state_t;

endpackage

/* rtl/ctp_tick_if.sv */
`timescale 1ns/1ps
interface ctp_tick_if;
    logic [2:0] sel;
    logic       extra;
    logic       clear;
    logic       tick;

    modport timer (output sel, output extra, output clear, input tick);
    modport presc (input sel, input extra, input clear, output tick);
endinterface

/* rtl/ctp_prescaler.sv */
`timescale 1ns/1ps
module ctp_prescaler (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // tick channel
    ctp_tick_if.presc tk
);

    ctp_pkg::ctp_presc_state_t s_q;
    ctp_pkg::ctp_presc_state_t s_d;

    function automatic logic [ctp_pkg::EXP_W:0] div_exp(
        input logic [2:0] sel,
        input logic       extra
    );
        logic [ctp_pkg::EXP_W-1:0] e;
        logic                      ok;
        e = ctp_pkg::EXP_1;
        ok = 1'b1;
        case (sel)
            ctp_pkg::CK_DIV11: e = ctp_pkg::EXP_11;
            ctp_pkg::CK_DIV7:  e = ctp_pkg::EXP_7;
            ctp_pkg::CK_DIV5:  e = ctp_pkg::EXP_5;
            ctp_pkg::CK_DIV3:  e = ctp_pkg::EXP_3;
            ctp_pkg::CK_DIV2:  e = ctp_pkg::EXP_2;
            ctp_pkg::CK_DIV1:  e = ctp_pkg::EXP_1;
            default:           ok = 1'b0;
        endcase
        if (extra) begin
            e = e + ctp_pkg::EXP_EXTRA;
        end
        return {ok, e};
    endfunction

    logic [ctp_pkg::EXP_W:0]   de;
    logic [ctp_pkg::PRESC_W-1:0] mask;

    assign de = div_exp(tk.sel, tk.extra);
    assign mask = (ctp_pkg::PRESC_ONE << de[ctp_pkg::EXP_W-1:0])
                  - ctp_pkg::PRESC_ONE;
    assign tk.tick = s_q.tick;

    always_comb begin
        s_d = s_q;
        // cleared while stopped so the first tick lands one full period in
        if (tk.clear) begin
            s_d.cnt = ctp_pkg::PRESC_ZERO;
            s_d.tick = 1'b0;
        end else begin
            s_d.cnt = s_q.cnt + ctp_pkg::PRESC_ONE;
            s_d.tick = de[ctp_pkg::EXP_W] && ((s_q.cnt & mask) == mask);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

/* rtl/ctp_timer.sv */
// Behaviour
// - software-start timer counts internal clock; match A raises irq, clears, continues while cycle_select is 0
// - clock select picks prescaled clock; doubling with extra divider; code 110 unused
// - trigger edge on enabled input pin resets counter, even in plain timer mode
// - external-trigger timer starts counting at the selected active edge
// - successive trigger mode: match restarts; trigger stops, next trigger restarts
// - one-shot trigger mode: match raises irq, counter cleared and stopped
// - both-edges set: opposite edge clears and stops the counter
// - both-edges clear: opposite edges are ignored
// - event mode counts active pin edges; match A raises irq and clears
// - event compare checked on opposite edge; source keeps edges coming
// - pulse mode runs internal clock, started by software or trigger edge
// - pulse mode: each match with enabled A, B or C inverts output
// - pulse mode irq only at the highest enabled compare register
// - reset clears the output flip-flop to 0
// - initial-value bit preloads output flip-flop for chosen pulse polarity
// - writes to B and C ignored unless pulse mode enables them
// - register count 00 is A, 01 A and B, 10 all three
// - block reset clears counter, running flag and output, sets started, keeps compares and pending irq
// - disabled trigger input behaves as a constant 0 level
`timescale 1ns/1ps
module ctp_timer (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // control
    input  wire logic        run_control,
    input  wire logic        start_source_select,
    input  wire logic        both_edges_enable,
    input  wire logic        trigger_edge_polarity,
    input  wire logic        cycle_select,
    input  wire logic        ppg_mode,
    input  wire logic        output_ff_initial,
    input  wire logic        block_soft_reset,
    // configuration
    input  wire logic [2:0]  count_clock_select,
    input  wire logic        extra_divider_select,
    input  wire logic [1:0]  register_count_select,
    input  wire logic        trigger_input_disable,
    input  wire logic        trigger_pin_is_input,
    // compare register write port
    input  wire logic        cmp_wr_en,
    input  wire logic [1:0]  cmp_wr_sel,
    input  wire logic [15:0] cmp_wr_data,
    // pin
    input  wire logic        trigger_pin_in,
    // status and outputs
    output logic             compare_match_irq,
    output logic             pulse_out,
    output logic             counter_running,
    output logic [15:0]      count_value
);

    ctp_pkg::ctp_state_t s_q;
    ctp_pkg::ctp_state_t s_d;

    ctp_tick_if u_tk ();

    ctp_prescaler u_presc (
        .mclk  (mclk),
        .rst_n (rst_n),
        .tk    (u_tk)
    );

    logic                      trig_lvl;
    logic                      rise;
    logic                      fall;
    logic                      act_edge;
    logic                      opp_edge;
    logic                      event_mode;
    logic                      use_b;
    logic                      use_c;
    logic [ctp_pkg::CNT_W-1:0] top;
    logic                      hit_top;
    logic                      hit_any;
    logic                      tick_run;
    logic                      ppg_toggle;

    assign u_tk.sel = count_clock_select;
    assign u_tk.extra = extra_divider_select;
    assign u_tk.clear = !s_q.running;

    // only the second sync stage and later are looked at
    assign trig_lvl = trigger_input_disable ? 1'b0 : s_q.sync2;
    assign rise = trig_lvl && !s_q.prev && trigger_pin_is_input;
    assign fall = !trig_lvl && s_q.prev && trigger_pin_is_input;
    assign act_edge = trigger_edge_polarity ? fall : rise;
    assign opp_edge = trigger_edge_polarity ? rise : fall;
    assign event_mode = !ppg_mode && (count_clock_select == ctp_pkg::CK_EXT);

    // reserved count code behaves as A only
    assign use_b = ppg_mode && ((register_count_select == ctp_pkg::RC_AB) ||
                   (register_count_select == ctp_pkg::RC_ABC));
    assign use_c = ppg_mode &&
                   (register_count_select == ctp_pkg::RC_ABC);

    always_comb begin
        top = s_q.cmp_a;
        if (use_c) begin
            top = s_q.cmp_c;
        end else if (use_b) begin
            top = s_q.cmp_b;
        end
    end

    assign hit_top = (s_q.cnt == top);
    assign hit_any = (s_q.cnt == s_q.cmp_a) ||
                     (use_b && (s_q.cnt == s_q.cmp_b)) ||
                     (use_c && (s_q.cnt == s_q.cmp_c));
    assign tick_run = u_tk.tick && s_q.running && run_control &&
                      !event_mode;
    assign ppg_toggle = ppg_mode && tick_run && hit_any &&
                        !block_soft_reset;

    always_comb begin
        s_d = s_q;
        s_d.sync1 = trigger_pin_in;
        s_d.sync2 = s_q.sync1;
        s_d.prev = trig_lvl;
        s_d.irq = 1'b0;

        if (cmp_wr_en) begin
            if (cmp_wr_sel == ctp_pkg::SEL_A) begin
                s_d.cmp_a = cmp_wr_data;
            end else if (cmp_wr_sel == ctp_pkg::SEL_B && use_b) begin
                s_d.cmp_b = cmp_wr_data;
            end else if (cmp_wr_sel == ctp_pkg::SEL_C && use_c) begin
                s_d.cmp_c = cmp_wr_data;
            end
        end

        if (!run_control) begin
            s_d.cnt = ctp_pkg::CNT_ZERO;
            s_d.running = 1'b0;
            s_d.started = 1'b0;
            if (ppg_mode) begin
                s_d.ff = output_ff_initial;
            end
        end else begin
            if (!start_source_select && !s_q.started) begin
                s_d.running = 1'b1;
                s_d.started = 1'b1;
            end
            if (event_mode) begin
                if (act_edge && s_q.running) begin
                    s_d.cnt = s_q.cnt + ctp_pkg::CNT_ONE;
                end else if (opp_edge && s_q.cnt == s_q.cmp_a) begin
                    s_d.irq = 1'b1;
                    s_d.cnt = ctp_pkg::CNT_ZERO;
                end
            end else begin
                if (tick_run) begin
                    if (ppg_toggle) begin
                        s_d.ff = !s_q.ff;
                    end
                    if (hit_top) begin
                        s_d.irq = 1'b1;
                        s_d.cnt = ctp_pkg::CNT_ZERO;
                        if (cycle_select) begin
                            s_d.running = 1'b0;
                        end
                    end else begin
                        s_d.cnt = s_q.cnt + ctp_pkg::CNT_ONE;
                    end
                end
                if (start_source_select) begin
                    if (act_edge) begin
                        s_d.cnt = ctp_pkg::CNT_ZERO;
                        // successive timer toggles stop/run on each trigger
                        if (!cycle_select && !ppg_mode) begin
                            s_d.running = !s_q.running;
                        end else begin
                            s_d.running = 1'b1;
                        end
                    end else if (opp_edge && both_edges_enable) begin
                        s_d.cnt = ctp_pkg::CNT_ZERO;
                        s_d.running = 1'b0;
                    end
                    // opposite edge with one-edge select falls through
                end else if (act_edge || opp_edge) begin
                    s_d.cnt = ctp_pkg::CNT_ZERO;
                end
            end
        end

        // irq already decided this cycle survives the block reset
        if (block_soft_reset) begin
            s_d.cnt = ctp_pkg::CNT_ZERO;
            s_d.running = 1'b0;
            s_d.started = 1'b1;
            s_d.ff = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign compare_match_irq = s_q.irq;
    assign pulse_out = s_q.ff;
    assign counter_running = s_q.running;
    assign count_value = s_q.cnt;

    AST_IRQ_CLEARS: assert property (
        @(posedge mclk) disable iff (!rst_n)
        s_q.irq |-> s_q.cnt == ctp_pkg::CNT_ZERO)
        else $error("counter not cleared with match irq");

    AST_B_WRITE_GUARD: assert property (
        @(posedge mclk) disable iff (!rst_n)
        cmp_wr_en && cmp_wr_sel == ctp_pkg::SEL_B && !use_b
        |=> $stable(s_q.cmp_b))
        else $error("compare B written while not enabled");

    AST_SOFT_RESET: assert property (
        @(posedge mclk) disable iff (!rst_n)
        block_soft_reset |=> !pulse_out && count_value == ctp_pkg::CNT_ZERO
        && !counter_running)
        else $error("block reset left state behind");

    AST_ONESHOT_STOP: assert property (
        @(posedge mclk) disable iff (!rst_n)
        tick_run && hit_top && cycle_select && !act_edge
        |=> !counter_running && compare_match_irq)
        else $error("one-shot did not stop at match");

    AST_PPG_TOGGLE: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ppg_toggle |=> pulse_out != $past(pulse_out))
        else $error("output not inverted on compare match");

    AST_PPG_IRQ_TOP: assert property (
        @(posedge mclk) disable iff (!rst_n)
        compare_match_irq && ppg_mode && $past(ppg_mode)
        |-> $past(s_q.cnt) == $past(top))
        else $error("pulse irq away from top register");

    AST_EVENT_COUNT: assert property (
        @(posedge mclk) disable iff (!rst_n)
        event_mode && run_control && act_edge && s_q.running
        && !block_soft_reset
        |=> count_value == $past(s_q.cnt) + ctp_pkg::CNT_ONE)
        else $error("event edge not counted");

    AST_BOTH_EDGE_STOP: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !event_mode && run_control && start_source_select && opp_edge
        && both_edges_enable
        |=> !counter_running && count_value == ctp_pkg::CNT_ZERO)
        else $error("opposite edge did not stop counter");

    AST_PRELOAD: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !run_control && ppg_mode && !block_soft_reset
        |=> pulse_out == $past(output_ff_initial))
        else $error("output not preloaded while stopped");

    AST_C_WRITE_GUARD: assert property (
        @(posedge mclk) disable iff (!rst_n)
        cmp_wr_en && cmp_wr_sel == ctp_pkg::SEL_C && !use_c
        |=> $stable(s_q.cmp_c))
        else $error("compare C written while not enabled");

    AST_SW_START: assert property (
        @(posedge mclk) disable iff (!rst_n)
        run_control && !start_source_select && !s_q.started
        && !s_q.running && !block_soft_reset
        |=> counter_running)
        else $error("software start did not start counter");

    AST_TRIG_START: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !event_mode && run_control && start_source_select && act_edge
        && (cycle_select || ppg_mode) && !block_soft_reset
        |=> counter_running && count_value == ctp_pkg::CNT_ZERO)
        else $error("active edge did not start counter");

    AST_PIN_CLEAR: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !event_mode && run_control && !start_source_select
        && (rise || fall)
        |=> count_value == ctp_pkg::CNT_ZERO)
        else $error("pin edge did not clear counter");

    AST_PPG_WRAP: assert property (
        @(posedge mclk) disable iff (!rst_n)
        tick_run && hit_top && ppg_mode && !cycle_select && !opp_edge
        && !block_soft_reset
        |=> counter_running && count_value == ctp_pkg::CNT_ZERO)
        else $error("pulse cycle did not wrap at top");

    COV_PPG_IRQ: cover property (
        @(posedge mclk) disable iff (!rst_n)
        compare_match_irq && ppg_mode && use_c);

    COV_EVENT_IRQ: cover property (
        @(posedge mclk) disable iff (!rst_n)
        compare_match_irq && event_mode);

    COV_TRIG_RESTART: cover property (
        @(posedge mclk) disable iff (!rst_n)
        start_source_select && !counter_running ##1 counter_running);

    COV_ONESHOT_DONE: cover property (
        @(posedge mclk) disable iff (!rst_n)
        cycle_select && compare_match_irq && !counter_running);

endmodule

/* tb/ctp_pin_src.sv */
`timescale 1ns/1ps
// far-side pulse source on the trigger pin; rests low between bursts
module ctp_pin_src (
    // clock
    input  wire logic       mclk,
    // burst request
    input  wire logic       go,
    input  wire logic [7:0] npulse,
    input  wire logic [7:0] half,
    // pin side
    output logic            pin,
    output logic            busy
);
    initial begin
        pin  = 1'b0;
        busy = 1'b0;
    end
    // half of 4 or more keeps each level at least four clocks
    // edges keep coming through the burst so compares get seen
    always @(posedge mclk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            for (int i = 0; i < npulse; i++) begin
                pin <= 1'b1;
                repeat (half) @(posedge mclk);
                pin <= 1'b0;
                repeat (half) @(posedge mclk);
            end
            busy <= 1'b0;
        end
    end
endmodule

/* tb/test_ctp_timer.sv */
`timescale 1ns/1ps
module test_ctp_timer;
    logic        mclk = 1'b0, rst_n = 1'b0;
    logic        run_control = 0, start_source_select = 0;
    logic        both_edges_enable = 0, trigger_edge_polarity = 0;
    logic        cycle_select = 0, ppg_mode = 0, output_ff_initial = 0;
    logic        block_soft_reset = 0, extra_divider_select = 0;
    logic [2:0]  count_clock_select = 3'h5;
    logic [1:0]  register_count_select = 2'h0, cmp_wr_sel = 2'h0;
    logic        trigger_input_disable = 1, trigger_pin_is_input = 1;
    logic        cmp_wr_en = 0, go = 0, busy;
    logic [15:0] cmp_wr_data = 16'h0000;
    logic [7:0]  npulse = 8'h01, half = 8'h08;
    logic        trigger_pin_in, compare_match_irq, pulse_out;
    logic        counter_running, pout_prev = 1'b0;
    logic [15:0] count_value;
    logic [31:0] seed = 32'hD719D2C0;
    int          err_count = 0, checked = 0, irqs = 0, tgl = 0, n;
    int          a, b, c, top;

    always #2.5 mclk = ~mclk;

    ctp_timer uut (.mclk, .rst_n, .run_control, .start_source_select,
        .both_edges_enable, .trigger_edge_polarity, .cycle_select,
        .ppg_mode, .output_ff_initial, .block_soft_reset,
        .count_clock_select, .extra_divider_select, .register_count_select,
        .trigger_input_disable, .trigger_pin_is_input, .cmp_wr_en,
        .cmp_wr_sel, .cmp_wr_data, .trigger_pin_in, .compare_match_irq,
        .pulse_out, .counter_running, .count_value);

    ctp_pin_src src (.mclk, .go, .npulse, .half, .pin(trigger_pin_in),
        .busy);

    // bench-side event counts, sampled before this edge's updates land
    always @(posedge mclk) begin
        if (compare_match_irq === 1'b1) irqs++;
        if (pulse_out !== pout_prev) tgl++;
        pout_prev = pulse_out;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic int div_exp(input logic [2:0] code, input logic ex);
        int e;
        case (code)
            3'h0: e = 11;
            3'h1: e = 7;
            3'h2: e = 5;
            3'h3: e = 3;
            3'h4: e = 2;
            default: e = 1;
        endcase
        return e + int'(ex);
    endfunction

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task automatic wr(input logic [1:0] sel, input int v);
        cmp_wr_en = 1'b1;
        cmp_wr_sel = sel;
        cmp_wr_data = v[15:0];
        cyc(1);
        cmp_wr_en = 1'b0;
        // idle edge so a following write never reassigns the strobe
        cyc(1);
    endtask

    // cycles from the call to the irq pulse, then steps past it
    task automatic wait_irq(input int lim, output int k);
        k = 0;
        while (compare_match_irq !== 1'b1) begin
            cyc(1);
            k++;
            if (k > lim) begin
                chk("irq wait", 1'b0, 1'b1);
                test_done();
            end
        end
        cyc(1);
    endtask

    task automatic burst(input int np, input int hp);
        int k;
        npulse = np[7:0];
        half = hp[7:0];
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        for (k = 0; busy === 1'b1; k++) begin
            cyc(1);
            if (k > 3000) begin
                chk("pin burst end", busy, 1'b0);
                test_done();
            end
        end
    endtask

    task automatic stop();
        run_control = 1'b0;
        cyc(3);
    endtask

    initial begin
        cyc(3);
        rst_n = 1'b1;
        chk("pulse_out after reset", pulse_out, 0);
        // software-start timer, every internal clock code, both dividers
        for (int k = 0; k < 12; k++) begin
            count_clock_select = 3'(k / 2);
            extra_divider_select = k[0];
            a = (k < 6) ? 2 : 2 + int'(rnd() % 4);
            wr(ctp_pkg::SEL_A, a);
            run_control = 1'b1;
            wait_irq(20000, n);
            wait_irq(20000, n);
            chk("timer period", n + 1, (a + 1) << div_exp(
                count_clock_select, extra_divider_select));
            stop();
        end
        extra_divider_select = 1'b0;
        count_clock_select = 3'h5;
        // pin edge clears a plain timer when the input is enabled
        trigger_input_disable = 1'b0;
        wr(ctp_pkg::SEL_A, 16'h0100);
        run_control = 1'b1;
        cyc(40);
        burst(1, 4);
        chk("count after pin edge", count_value < 16'h0006, 1);
        // pin as output: its edges must leave the count alone
        trigger_pin_is_input = 1'b0;
        burst(1, 4);
        chk("count with pin output", count_value > 16'h0003, 1);
        trigger_pin_is_input = 1'b1;
        stop();
        // one-shot trigger start: narrow pulse, opposite edge ignored
        start_source_select = 1'b1;
        cycle_select = 1'b1;
        wr(ctp_pkg::SEL_A, 4);
        run_control = 1'b1;
        cyc(5);
        chk("idle before trigger", counter_running, 0);
        burst(1, 4);
        irqs = 0;
        cyc(20);
        chk("one-shot irq", irqs, 1);
        chk("one-shot stopped", counter_running, 0);
        chk("one-shot count", count_value, 0);
        // both edges: falling edge before the match stops it
        both_edges_enable = 1'b1;
        irqs = 0;
        burst(1, 4);
        cyc(20);
        chk("both-edge irq", irqs, 0);
        chk("both-edge stopped", counter_running, 0);
        // successive trigger: second trigger stops, third restarts
        both_edges_enable = 1'b0;
        cycle_select = 1'b0;
        burst(1, 4);
        chk("running after trigger", counter_running, 1);
        burst(1, 4);
        chk("stopped by trigger", counter_running, 0);
        burst(1, 4);
        chk("restarted by trigger", counter_running, 1);
        stop();
        // event counting on rising pin edges
        start_source_select = 1'b0;
        count_clock_select = 3'h7;
        a = 2 + int'(rnd() % 4);
        wr(ctp_pkg::SEL_A, a);
        run_control = 1'b1;
        cyc(2);
        irqs = 0;
        burst(2 * a, 4);
        cyc(6);
        chk("event irqs", irqs, 2);
        stop();
        // pulse generator, each register count
        count_clock_select = 3'h5;
        trigger_input_disable = 1'b1;
        ppg_mode = 1'b1;
        for (int rc = 0; rc < 3; rc++) begin
            register_count_select = 2'(rc);
            a = 2 + int'(rnd() % 3);
            b = a + 2 + int'(rnd() % 3);
            c = b + 2 + int'(rnd() % 3);
            wr(ctp_pkg::SEL_A, a);
            wr(ctp_pkg::SEL_B, b);
            wr(ctp_pkg::SEL_C, c);
            top = (rc == 0) ? a : (rc == 1) ? b : c;
            run_control = 1'b1;
            wait_irq(500, n);
            tgl = 0;
            irqs = 0;
            wait_irq(500, n);
            chk("ppg period", n + 1, (top + 1) * 2);
            chk("ppg toggles", tgl, rc + 1);
            chk("ppg irqs", irqs, 1);
            stop();
        end
        output_ff_initial = 1'b1;
        cyc(3);
        chk("ppg preload", pulse_out, 1);
        run_control = 1'b1;
        cyc(9);
        block_soft_reset = 1'b1;
        cyc(1);
        block_soft_reset = 1'b0;
        cyc(1);
        chk("soft reset output", pulse_out, 0);
        chk("soft reset running", counter_running, 0);
        chk("soft reset count", count_value, 0);
        test_done();
    end
endmodule
